/* shared/mprs_defines.svh */
/*
 Constants of the module power and reset sequencer: pin slot positions,
 reset values and timing counts.
 Assumes a 200 MHz clock; included by the package and the design files.
*/
`ifndef MPRS_DEFINES_SVH
`define MPRS_DEFINES_SVH

// Clock period in ns
`define MPRS_CLK_PERIOD_NS 5

// Reset output hold time after carrier power comes on, in ns
`define MPRS_SETTLE_NS 10000

// Least time rounds up to whole cycles
`define MPRS_SETTLE_CYCLES ((`MPRS_SETTLE_NS + `MPRS_CLK_PERIOD_NS - 1) / `MPRS_CLK_PERIOD_NS)
`define MPRS_SETTLE_W 11

// Slots of the synchronised carrier pin vector
`define MPRS_PIN_W 6
`define MPRS_PIN_SUPPLY 0
`define MPRS_PIN_PWR_BAD_N 1
`define MPRS_PIN_RST_REQ_N 2
`define MPRS_PIN_BUTTON_N 3
`define MPRS_PIN_RECOVERY_N 4
`define MPRS_PIN_AUTO_ON 5

// Synchroniser reset value: no supply, power bad, reset requested, button and recovery idle
`define MPRS_PIN_RESET 6'h18

// Pins that default to inputs with pull-downs: 14 GPIO, 3 straps, battery low, test,
// charge active, charger present
`define MPRS_GPIO_W 21
`define MPRS_GPIO_PD_RESET 21'h1f_ffff
`define MPRS_GPIO_OE_RESET 21'h00_0000

`endif

/* shared/mprs_pkg.sv */
/*
 Types of the module power and reset sequencer.
 Assumes mprs_defines.svh is on the include path.
*/
`include "mprs_defines.svh"

package mprs_pkg;

   typedef enum logic [2:0] {
      mprs_off,
      mprs_wait_start,
      mprs_settle,
      mprs_wait_release,
      mprs_run,
      mprs_suspend
   } mprs_state_t;

   typedef struct packed {
      logic [`MPRS_PIN_W-1:0] stage1;
      logic [`MPRS_PIN_W-1:0] stage2;
   } mprs_sync_t;

   typedef struct packed {
      mprs_state_t state;
      logic [`MPRS_SETTLE_W-1:0] settle_cnt;
      logic button_prev;
      logic gpio_init;
      logic internal_power_enable;
      logic carrier_power_enable;
      logic carrier_standby_n;
      logic main_core_power_enable;
      logic reset_out_n;
      logic boot_start;
      logic serial_download_mode;
      logic fuse_boot_select;
      logic [`MPRS_GPIO_W-1:0] gpio_output_enable;
      logic [`MPRS_GPIO_W-1:0] gpio_pull_down;
   } mprs_top_t;

endpackage

/* shared/mprs_pin_if.sv */
/*
 Synchronised carrier pin levels passed from the synchroniser to the sequencer.
 Assumes both ends run on the same clock.
*/
interface mprs_pin_if;
   logic supply_present;
   logic input_power_bad_n;
   logic reset_request_n;
   logic power_button_n;
   logic recovery_request_n;
   logic auto_power_on;

   modport sync_side (
      output supply_present,
      output input_power_bad_n,
      output reset_request_n,
      output power_button_n,
      output recovery_request_n,
      output auto_power_on
   );

   modport seq_side (
      input supply_present,
      input input_power_bad_n,
      input reset_request_n,
      input power_button_n,
      input recovery_request_n,
      input auto_power_on
   );
endinterface

/* verilog/mprs_sync.sv */
/*
 Two-flop synchroniser for the asynchronous carrier pins.
 Assumes raw pins arrive from outside the clock domain; only stage two is read.
*/
`include "mprs_defines.svh"

module mprs_sync (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Raw carrier pins
   input wire logic [`MPRS_PIN_W-1:0] raw_pins,
   // Synchronised levels
   mprs_pin_if.sync_side pins
);

   mprs_pkg::mprs_sync_t cur;
   mprs_pkg::mprs_sync_t next_cur;

   always_comb begin
      next_cur.stage1 = raw_pins;
      next_cur.stage2 = cur.stage1;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cur.stage1 <= `MPRS_PIN_RESET;
         cur.stage2 <= `MPRS_PIN_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   // Only the second stage leaves this module
   assign pins.supply_present = cur.stage2[`MPRS_PIN_SUPPLY];
   assign pins.input_power_bad_n = cur.stage2[`MPRS_PIN_PWR_BAD_N];
   assign pins.reset_request_n = cur.stage2[`MPRS_PIN_RST_REQ_N];
   assign pins.power_button_n = cur.stage2[`MPRS_PIN_BUTTON_N];
   assign pins.recovery_request_n = cur.stage2[`MPRS_PIN_RECOVERY_N];
   assign pins.auto_power_on = cur.stage2[`MPRS_PIN_AUTO_ON];

endmodule

/* verilog/mprs_top.sv */
/*
 Power-up, reset and boot-control sequencer of a plug-in compute module.
 Assumes one 200 MHz clock with synchronous active-high reset; carrier pins are
 asynchronous, processor-side controls are on the same clock.
*/
`include "mprs_defines.svh"

module mprs_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Carrier pins, asynchronous
   input wire logic main_supply_present,
   input wire logic input_power_bad_n,
   input wire logic reset_request_n,
   input wire logic power_button_n,
   input wire logic recovery_request_n,
   input wire logic auto_power_on,
   // Processor side
   input wire logic sw_reset_out_n,
   input wire logic sw_gpio_init,
   input wire logic [`MPRS_GPIO_W-1:0] sw_gpio_output_enable,
   input wire logic [`MPRS_GPIO_W-1:0] sw_gpio_pull_down,
   // Power control outputs
   output logic internal_power_enable,
   output logic carrier_power_enable,
   output logic carrier_standby_n,
   output logic main_core_power_enable,
   // Reset and boot outputs
   output logic reset_out_n,
   output logic boot_start,
   output logic serial_download_mode,
   output logic fuse_boot_select,
   // General purpose pin control
   output logic [`MPRS_GPIO_W-1:0] gpio_output_enable,
   output logic [`MPRS_GPIO_W-1:0] gpio_pull_down
);

   localparam logic [`MPRS_SETTLE_W-1:0] SETTLE_LAST = `MPRS_SETTLE_W'(`MPRS_SETTLE_CYCLES - 1);

   mprs_pin_if pins ();

   mprs_pkg::mprs_top_t cur;
   mprs_pkg::mprs_top_t next_cur;

   logic [`MPRS_PIN_W-1:0] raw_pins;

   // Pin vector into the synchroniser
   always_comb begin
      raw_pins = '0;
      raw_pins[`MPRS_PIN_SUPPLY] = main_supply_present;
      raw_pins[`MPRS_PIN_PWR_BAD_N] = input_power_bad_n;
      raw_pins[`MPRS_PIN_RST_REQ_N] = reset_request_n;
      raw_pins[`MPRS_PIN_BUTTON_N] = power_button_n;
      raw_pins[`MPRS_PIN_RECOVERY_N] = recovery_request_n;
      raw_pins[`MPRS_PIN_AUTO_ON] = auto_power_on;
   end

   mprs_sync mprs_sync_inst (
      .clock(clock),
      .rst(rst),
      .raw_pins(raw_pins),
      .pins(pins)
   );

   // Falling edge of the synchronised button level
   function automatic logic button_event(input logic prev, input logic now);
      button_event = prev & ~now;
   endfunction

   // Input supply usable: present and power-bad released
   function automatic logic supply_good(input logic present, input logic bad_n);
      supply_good = present & bad_n;
   endfunction

   logic power_ok;
   logic pressed;

   always_comb begin
      power_ok = supply_good(pins.supply_present, pins.input_power_bad_n);
      pressed = button_event(cur.button_prev, pins.power_button_n);
   end

   always_comb begin
      next_cur = cur;
      next_cur.button_prev = pins.power_button_n;
      next_cur.boot_start = 1'b0;
      next_cur.fuse_boot_select = 1'b1;

      case (cur.state)
         mprs_pkg::mprs_off: begin
            next_cur.internal_power_enable = 1'b0;
            next_cur.carrier_power_enable = 1'b0;
            next_cur.carrier_standby_n = 1'b0;
            next_cur.main_core_power_enable = 1'b0;
            next_cur.settle_cnt = '0;
            if (power_ok) begin
               next_cur.internal_power_enable = 1'b1;
               next_cur.state = mprs_pkg::mprs_wait_start;
            end
         end
         mprs_pkg::mprs_wait_start: begin
            if (pins.auto_power_on || pressed) begin
               next_cur.carrier_power_enable = 1'b1;
               next_cur.carrier_standby_n = 1'b1;
               next_cur.main_core_power_enable = 1'b1;
               next_cur.settle_cnt = '0;
               next_cur.state = mprs_pkg::mprs_settle;
            end
         end
         mprs_pkg::mprs_settle: begin
            if (cur.settle_cnt == SETTLE_LAST) begin
               next_cur.state = mprs_pkg::mprs_wait_release;
            end else begin
               next_cur.settle_cnt = cur.settle_cnt + 1'b1;
            end
         end
         mprs_pkg::mprs_wait_release: begin
            if (pins.reset_request_n) begin
               next_cur.boot_start = 1'b1;
               next_cur.serial_download_mode = ~pins.recovery_request_n;
               next_cur.state = mprs_pkg::mprs_run;
            end
         end
         mprs_pkg::mprs_run: begin
            if (!pins.reset_request_n) begin
               next_cur.settle_cnt = '0;
               next_cur.state = mprs_pkg::mprs_settle;
            end else if (pressed) begin
               next_cur.carrier_standby_n = 1'b0;
               next_cur.main_core_power_enable = 1'b0;
               next_cur.state = mprs_pkg::mprs_suspend;
            end
         end
         mprs_pkg::mprs_suspend: begin
            if (!pins.reset_request_n) begin
               next_cur.carrier_standby_n = 1'b1;
               next_cur.main_core_power_enable = 1'b1;
               next_cur.settle_cnt = '0;
               next_cur.state = mprs_pkg::mprs_settle;
            end else if (pressed) begin
               next_cur.carrier_standby_n = 1'b1;
               next_cur.main_core_power_enable = 1'b1;
               next_cur.state = mprs_pkg::mprs_run;
            end
         end
         default: begin
            next_cur.state = mprs_pkg::mprs_off;
         end
      endcase

      // Loss of input power drops all power enables, boot_start, serial_download_mode and gpio_init
      if (!power_ok) begin
         next_cur.state = mprs_pkg::mprs_off;
         next_cur.internal_power_enable = 1'b0;
         next_cur.carrier_power_enable = 1'b0;
         next_cur.carrier_standby_n = 1'b0;
         next_cur.main_core_power_enable = 1'b0;
         next_cur.boot_start = 1'b0;
         next_cur.serial_download_mode = 1'b0;
         next_cur.gpio_init = 1'b0;
      end

      // Reset output: sequencer release gated by the software output
      if (next_cur.state == mprs_pkg::mprs_run || next_cur.state == mprs_pkg::mprs_suspend) begin
         next_cur.reset_out_n = sw_reset_out_n;
      end else begin
         next_cur.reset_out_n = 1'b0;
      end

      // Pins stay pulled-down inputs until software takes them over
      if (sw_gpio_init && next_cur.state == mprs_pkg::mprs_run) begin
         next_cur.gpio_init = 1'b1;
      end
      if (next_cur.gpio_init) begin
         next_cur.gpio_output_enable = sw_gpio_output_enable;
         next_cur.gpio_pull_down = sw_gpio_pull_down;
      end else begin
         next_cur.gpio_output_enable = `MPRS_GPIO_OE_RESET;
         next_cur.gpio_pull_down = `MPRS_GPIO_PD_RESET;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cur.state <= mprs_pkg::mprs_off;
         cur.settle_cnt <= '0;
         cur.button_prev <= 1'b1;
         cur.gpio_init <= 1'b0;
         cur.internal_power_enable <= 1'b0;
         cur.carrier_power_enable <= 1'b0;
         cur.carrier_standby_n <= 1'b0;
         cur.main_core_power_enable <= 1'b0;
         cur.reset_out_n <= 1'b0;
         cur.boot_start <= 1'b0;
         cur.serial_download_mode <= 1'b0;
         cur.fuse_boot_select <= 1'b1;
         cur.gpio_output_enable <= `MPRS_GPIO_OE_RESET;
         cur.gpio_pull_down <= `MPRS_GPIO_PD_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs straight from the state register
   assign internal_power_enable = cur.internal_power_enable;
   assign carrier_power_enable = cur.carrier_power_enable;
   assign carrier_standby_n = cur.carrier_standby_n;
   assign main_core_power_enable = cur.main_core_power_enable;
   assign reset_out_n = cur.reset_out_n;
   assign boot_start = cur.boot_start;
   assign serial_download_mode = cur.serial_download_mode;
   assign fuse_boot_select = cur.fuse_boot_select;
   assign gpio_output_enable = cur.gpio_output_enable;
   assign gpio_pull_down = cur.gpio_pull_down;

endmodule

/* bench/mprs_top_props.sv */
/*
 Port checker of the power and reset sequencer.
 Assumes it is bound into mprs_top and sees only its ports.
*/
`include "mprs_defines.svh"

module mprs_top_props (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Watched inputs
   input wire logic input_power_bad_n,
   input wire logic reset_request_n,
   input wire logic sw_reset_out_n,
   // Watched outputs
   input wire logic internal_power_enable,
   input wire logic carrier_power_enable,
   input wire logic carrier_standby_n,
   input wire logic main_core_power_enable,
   input wire logic reset_out_n,
   input wire logic boot_start,
   input wire logic fuse_boot_select,
   input wire logic [`MPRS_GPIO_W-1:0] gpio_output_enable
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Cycles since carrier power came on
   logic [11:0] on_cnt;
   always_ff @(posedge clock) begin
      if (rst || !carrier_power_enable) begin
         on_cnt <= 12'h000;
      end else if (on_cnt != 12'hfff) begin
         on_cnt <= on_cnt + 12'h001;
      end
   end
   sequence s_power_start;
      $rose(carrier_power_enable);
   endsequence
   sequence s_boot;
      boot_start ##1 !boot_start;
   endsequence
   AST_POWER_GOOD: assert property (internal_power_enable |-> $past(input_power_bad_n, 3))
      else $error("internal power on while input bad");
   AST_CARRIER_INTERNAL: assert property (carrier_power_enable |-> internal_power_enable)
      else $error("carrier power without internal power");
   AST_START_STANDBY: assert property (s_power_start |-> carrier_standby_n && !reset_out_n)
      else $error("start without standby or with reset released");
   AST_SETTLE_TIME: assert property (boot_start |-> on_cnt >= 12'(`MPRS_SETTLE_CYCLES))
      else $error("reset released before settle time");
   AST_BOOT_RELEASE: assert property (boot_start |-> reset_out_n == $past(sw_reset_out_n) && $past(reset_request_n, 3))
      else $error("boot while reset requested");
   AST_REQUEST_RESET: assert property (!$past(reset_request_n, 3) |-> !reset_out_n)
      else $error("reset request ignored");
   AST_SW_RESET: assert property (!$past(sw_reset_out_n) |-> !reset_out_n)
      else $error("software reset ignored");
   AST_SUSPEND_CORE: assert property (!carrier_standby_n |-> !main_core_power_enable)
      else $error("core powered in standby");
   AST_BOOT_PULSE: assert property (boot_start |-> s_boot)
      else $error("boot start longer than one cycle");
   AST_FUSE_BOOT: assert property (fuse_boot_select)
      else $error("fuse boot not selected");
   AST_GPIO_DEFAULT: assert property (!internal_power_enable [*2] |-> gpio_output_enable == '0)
      else $error("gpio driven while off");
endmodule

bind mprs_top mprs_top_props mprs_top_props_inst (.clock, .rst, .input_power_bad_n, .reset_request_n,
   .sw_reset_out_n, .internal_power_enable, .carrier_power_enable, .carrier_standby_n,
   .main_core_power_enable, .reset_out_n, .boot_start, .fuse_boot_select, .gpio_output_enable);

/* bench/mprs_carrier_model.sv */
/*
 Carrier board model driving the power and reset pins.
 Assumes tasks are called just after a rising clock edge.
*/
module mprs_carrier_model (
   // Clock
   input wire logic clock,
   // Carrier pins
   output logic main_supply_present,
   output logic input_power_bad_n,
   output logic reset_request_n,
   output logic power_button_n,
   output logic recovery_request_n,
   output logic auto_power_on
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      main_supply_present = 1'b0;
      input_power_bad_n = 1'b0;
      reset_request_n = 1'b1;
      power_button_n = 1'b1;
      recovery_request_n = 1'b1;
      auto_power_on = 1'b1;
   end
   task automatic edges(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Power good only once the supply is stable
   task automatic power_on();
      main_supply_present = 1'b1;
      edges(4);
      input_power_bad_n = 1'b1;
   endtask
   task automatic power_off();
      input_power_bad_n = 1'b0;
      main_supply_present = 1'b0;
   endtask
   task automatic press();
      power_button_n = 1'b0;
      edges(4);
      power_button_n = 1'b1;
      edges(4);
   endtask
   task automatic set_request(input logic v);
      reset_request_n = v;
   endtask
   task automatic set_mode(input logic auto_on, input logic recov_n);
      auto_power_on = auto_on;
      recovery_request_n = recov_n;
   endtask
endmodule

/* bench/tb_mprs_top.sv */
/*
 Self-checking bench of the sequencer with the carrier model.
 Assumes the checker binds itself into mprs_top.
*/
`include "mprs_defines.svh"

module tb_mprs_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic main_supply_present, input_power_bad_n, reset_request_n, power_button_n;
   logic recovery_request_n, auto_power_on;
   logic sw_reset_out_n = 1'b1;
   logic sw_gpio_init = 1'b0;
   logic [`MPRS_GPIO_W-1:0] sw_gpio_output_enable = '0;
   logic [`MPRS_GPIO_W-1:0] sw_gpio_pull_down = '0;
   logic internal_power_enable, carrier_power_enable, carrier_standby_n, main_core_power_enable;
   logic reset_out_n, boot_start, serial_download_mode, fuse_boot_select;
   logic [`MPRS_GPIO_W-1:0] gpio_output_enable, gpio_pull_down;
   int err_count = 0;
   int n_checks = 0;

   initial begin
      forever #2.5 clock = ~clock;
   end

   mprs_carrier_model mprs_carrier_model_inst (.clock, .main_supply_present, .input_power_bad_n,
      .reset_request_n, .power_button_n, .recovery_request_n, .auto_power_on);
   mprs_top mprs_top_inst (.clock, .rst, .main_supply_present, .input_power_bad_n, .reset_request_n,
      .power_button_n, .recovery_request_n, .auto_power_on, .sw_reset_out_n, .sw_gpio_init,
      .sw_gpio_output_enable, .sw_gpio_pull_down, .internal_power_enable, .carrier_power_enable,
      .carrier_standby_n, .main_core_power_enable, .reset_out_n, .boot_start, .serial_download_mode,
      .fuse_boot_select, .gpio_output_enable, .gpio_pull_down);

   task automatic check(input string name, input logic [20:0] seen, input logic [20:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic wait_boot();
      for (int i = 0; i < 2200 && boot_start !== 1'b1; i++) begin
         tick(1);
      end
      check("boot_start", boot_start, 1'b1);
      if (boot_start !== 1'b1) begin
         conclude();
      end
   endtask

   task automatic s_auto_boot();
      check("gpio_oe", gpio_output_enable, '0);
      check("gpio_pd", gpio_pull_down, `MPRS_GPIO_PD_RESET);
      mprs_carrier_model_inst.power_on();
      tick(2);
      check("int_en", internal_power_enable, 1'b0);
      tick(1);
      check("int_en", internal_power_enable, 1'b1);
      tick(1);
      check("start", {carrier_power_enable, carrier_standby_n, reset_out_n}, 3'h6);
      tick(`MPRS_SETTLE_CYCLES);
      check("rst_out", reset_out_n, 1'b0);
      tick(1);
      check("boot_start", boot_start, 1'b1);
      check("boot", {reset_out_n, serial_download_mode, fuse_boot_select}, 3'h5);
      tick(1);
      check("boot_pulse", boot_start, 1'b0);
   endtask
   task automatic s_gpio();
      sw_gpio_output_enable = 21'h0a_5a5a;
      sw_gpio_pull_down = 21'h15_a5a5;
      sw_gpio_init = 1'b1;
      tick(2);
      sw_gpio_init = 1'b0;
      tick(1);
      check("gpio_oe", gpio_output_enable, 21'h0a_5a5a);
      check("gpio_pd", gpio_pull_down, 21'h15_a5a5);
   endtask
   task automatic s_sw_reset();
      sw_reset_out_n = 1'b0;
      tick(1);
      check("rst_out", reset_out_n, 1'b0);
      sw_reset_out_n = 1'b1;
      tick(1);
      check("rst_out", reset_out_n, 1'b1);
   endtask
   task automatic s_request();
      mprs_carrier_model_inst.set_request(1'b0);
      tick(3);
      check("rst_out", reset_out_n, 1'b0);
      tick(2100);
      check("rst_out", reset_out_n, 1'b0);
      mprs_carrier_model_inst.set_request(1'b1);
      wait_boot();
      check("rst_out", reset_out_n, 1'b1);
   endtask
   task automatic s_suspend();
      mprs_carrier_model_inst.press();
      check("suspend", {carrier_standby_n, main_core_power_enable, carrier_power_enable}, 3'h1);
      mprs_carrier_model_inst.press();
      check("wake", {carrier_standby_n, main_core_power_enable}, 2'h3);
   endtask
   task automatic s_power_loss();
      mprs_carrier_model_inst.set_mode(1'b0, 1'b0);
      mprs_carrier_model_inst.power_off();
      tick(4);
      check("off", {internal_power_enable, carrier_power_enable, carrier_standby_n, reset_out_n}, 4'h0);
      check("gpio_oe", gpio_output_enable, '0);
      mprs_carrier_model_inst.power_on();
      tick(20);
      check("car_en", carrier_power_enable, 1'b0);
      mprs_carrier_model_inst.press();
      check("car_en", carrier_power_enable, 1'b1);
      wait_boot();
      check("sdl", serial_download_mode, 1'b1);
   endtask

   initial begin
      tick(6);
      rst = 1'b0;
      s_auto_boot();
      s_gpio();
      s_sw_reset();
      s_request();
      s_suspend();
      s_power_loss();
      conclude();
   end
endmodule
